// file: logic/pmsc_top.sv
// PHY management serial controller with Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pmsc_top #(
	parameter int          PHYS      = 32,
	parameter logic [15:0] DIV_RESET = pmsc_pkg::DIV_RESET
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_n_o,
	output logic             mdc_o,
	output logic             done_event_o,
	output logic             link_event_o
);
	typedef enum logic [1:0] {TS_IDLE = 2'b01, TS_BUSY = 2'b10} pmsc_ts_t;

	// ***********************************************************
	// State
	// ***********************************************************
	pmsc_ts_t            st;
	logic                en;
	logic                nopre;
	logic [15:0]         bus_clock_divider;
	logic [PHYS-1:0]     responder_flags;
	logic [PHYS-1:0]     carrier_flags;
	logic [1:0]          carrier_change_raw_events;
	logic [1:0]          carrier_change_masked_events;
	logic [1:0]          request_done_raw_events;
	logic [1:0]          request_done_masked_events;
	logic [1:0]          done_mask;
	pmsc_pkg::pmsc_req_t user_request_register [2];
	logic [4:0]          monitored_phy_address [2];
	logic [1:0]          carrier_change_event_enable;
	logic [4:0]          poll_addr;
	logic                src_user;
	logic                src_idx;
	logic                rr_last;
	logic                start;
	pmsc_pkg::pmsc_cmd_t cmd;

	// Engine results
	logic                fr_done;
	logic                fr_ack;
	logic [15:0]         fr_rdata;
	logic                poll_done;
	logic                user_done;
	logic                new_carrier;

	// Bus decode
	logic                wr_acc;
	logic [31:0]         next_rdata;
	logic [31:0]         wmerged;
	logic                hit_ctrl;
	logic                hit_lraw;
	logic                hit_draw;
	logic                hit_mset;
	logic                hit_mclr;
	logic [1:0]          hit_req;
	logic [1:0]          hit_sel;
	logic                pick;

	function automatic logic [31:0] pmsc_be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction : pmsc_be_merge

	function automatic logic [31:0] pmsc_sel_word(input logic [4:0] a, input logic e);
		logic [31:0] r;
		r = 32'h0;
		r[4:0] = a;
		r[pmsc_pkg::SEL_EN] = e;
		return r;
	endfunction : pmsc_sel_word

	assign poll_done   = fr_done && !src_user;
	assign user_done   = fr_done && src_user;
	assign new_carrier = fr_ack && fr_rdata[pmsc_pkg::LINK_BIT];
	assign wr_acc      = avs_write_i && !avs_waitrequest_o;
	assign wmerged     = pmsc_be_merge(next_rdata, avs_writedata_i, avs_byteenable_i);

	assign carrier_change_masked_events = carrier_change_raw_events
		& carrier_change_event_enable;
	assign request_done_masked_events   = request_done_raw_events & done_mask;

	// ***********************************************************
	// Address decode
	// ***********************************************************
	always_comb begin
		hit_ctrl = 1'b0;
		hit_lraw = 1'b0;
		hit_draw = 1'b0;
		hit_mset = 1'b0;
		hit_mclr = 1'b0;
		hit_req  = 2'b00;
		hit_sel  = 2'b00;
		if (avs_address_i == pmsc_pkg::OFF_CTRL) begin
			hit_ctrl = wr_acc;
		end else if (avs_address_i == pmsc_pkg::OFF_LRAW) begin
			hit_lraw = wr_acc;
		end else if (avs_address_i == pmsc_pkg::OFF_DRAW) begin
			hit_draw = wr_acc;
		end else if (avs_address_i == pmsc_pkg::OFF_MSET) begin
			hit_mset = wr_acc;
		end else if (avs_address_i == pmsc_pkg::OFF_MCLR) begin
			hit_mclr = wr_acc;
		end else if (avs_address_i == pmsc_pkg::OFF_REQ0) begin
			hit_req[0] = wr_acc;
		end else if (avs_address_i == pmsc_pkg::OFF_REQ1) begin
			hit_req[1] = wr_acc;
		end else if (avs_address_i == pmsc_pkg::OFF_SEL0) begin
			hit_sel[0] = wr_acc;
		end else if (avs_address_i == pmsc_pkg::OFF_SEL1) begin
			hit_sel[1] = wr_acc;
		end
	end

	// ***********************************************************
	// Read mux; unmapped reads return zero
	// ***********************************************************
	always_comb begin
		next_rdata = 32'h0;
		if (avs_address_i == pmsc_pkg::OFF_CTRL) begin
			next_rdata[15:0]                 = bus_clock_divider;
			next_rdata[pmsc_pkg::CTRL_NOPRE] = nopre;
			next_rdata[pmsc_pkg::CTRL_EN]    = en;
			next_rdata[pmsc_pkg::CTRL_BUSY]  = (st == TS_BUSY);
		end else if (avs_address_i == pmsc_pkg::OFF_RESP) begin
			next_rdata[PHYS-1:0] = responder_flags;
		end else if (avs_address_i == pmsc_pkg::OFF_CARR) begin
			next_rdata[PHYS-1:0] = carrier_flags;
		end else if (avs_address_i == pmsc_pkg::OFF_LRAW) begin
			next_rdata[1:0] = carrier_change_raw_events;
		end else if (avs_address_i == pmsc_pkg::OFF_LMSK) begin
			next_rdata[1:0] = carrier_change_masked_events;
		end else if (avs_address_i == pmsc_pkg::OFF_DRAW) begin
			next_rdata[1:0] = request_done_raw_events;
		end else if (avs_address_i == pmsc_pkg::OFF_DMSK) begin
			next_rdata[1:0] = request_done_masked_events;
		end else if (avs_address_i == pmsc_pkg::OFF_MSET
			|| avs_address_i == pmsc_pkg::OFF_MCLR) begin
			next_rdata[1:0] = done_mask;
		end else if (avs_address_i == pmsc_pkg::OFF_REQ0) begin
			next_rdata = user_request_register[0];
		end else if (avs_address_i == pmsc_pkg::OFF_REQ1) begin
			next_rdata = user_request_register[1];
		end else if (avs_address_i == pmsc_pkg::OFF_SEL0) begin
			next_rdata = pmsc_sel_word(monitored_phy_address[0],
				carrier_change_event_enable[0]);
		end else if (avs_address_i == pmsc_pkg::OFF_SEL1) begin
			next_rdata = pmsc_sel_word(monitored_phy_address[1],
				carrier_change_event_enable[1]);
		end
	end

	// ***********************************************************
	// Bus handshake: one wait cycle per access
	// ***********************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
			avs_readdata_o    <= next_rdata;
		end
	end

	// ***********************************************************
	// Control register
	// ***********************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en                <= 1'b0;
			nopre             <= 1'b0;
			bus_clock_divider <= DIV_RESET;
		end else if (hit_ctrl) begin
			en                <= wmerged[pmsc_pkg::CTRL_EN];
			nopre             <= wmerged[pmsc_pkg::CTRL_NOPRE];
			bus_clock_divider <= wmerged[15:0];
		end
	end

	// ***********************************************************
	// Frame scheduling
	// ***********************************************************
	// Alternate when both requests wait
	assign pick = (user_request_register[0].pend && user_request_register[1].pend)
		? !rr_last : user_request_register[1].pend;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st       <= TS_IDLE;
			start    <= 1'b0;
			src_user <= 1'b0;
			src_idx  <= 1'b0;
			rr_last  <= 1'b1;
			cmd      <= '0;
		end else begin
			start <= 1'b0;
			case (st)
				TS_IDLE: begin
					// Disabled: frame in flight finishes, no new one starts
					if (en) begin
						st    <= TS_BUSY;
						start <= 1'b1;
						if (user_request_register[0].pend
							|| user_request_register[1].pend) begin
							src_user  <= 1'b1;
							src_idx   <= pick;
							rr_last   <= pick;
							cmd.wr    <= user_request_register[pick].wr;
							cmd.regad <= user_request_register[pick].regad;
							cmd.phy   <= user_request_register[pick].phy;
							cmd.data  <= user_request_register[pick].data;
						end else begin
							src_user  <= 1'b0;
							cmd.wr    <= 1'b0;
							cmd.regad <= pmsc_pkg::STATUS_REG;
							cmd.phy   <= poll_addr;
							cmd.data  <= 16'h0000;
						end
					end
				end
				TS_BUSY: begin
					if (fr_done) begin
						st <= TS_IDLE;
					end
				end
				default: st <= TS_IDLE;
			endcase
		end
	end

	// ***********************************************************
	// Poll address walks 0..31 and wraps
	// ***********************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			poll_addr <= 5'h00;
		end else if (poll_done) begin
			poll_addr <= poll_addr + 5'h01;
		end
	end

	// ***********************************************************
	// Responder and carrier flags
	// ***********************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			responder_flags <= '0;
			carrier_flags   <= '0;
		end else if (poll_done) begin
			responder_flags[poll_addr] <= fr_ack;
			carrier_flags[poll_addr]   <= new_carrier;
		end else if (user_done && !cmd.wr) begin
			responder_flags[cmd.phy] <= fr_ack;
		end
	end

	// ***********************************************************
	// Per-slot logic: requests, monitors, events
	// ***********************************************************
	for (genvar i = 0; i < 2; i++) begin : g_slot
		logic fin;
		logic chg;
		assign fin = user_done && (src_idx == 1'(i));
		assign chg = poll_done && carrier_change_event_enable[i]
			&& monitored_phy_address[i] == poll_addr
			&& carrier_flags[poll_addr] != new_carrier;

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				user_request_register[i] <= '0;
			end else if (hit_req[i]) begin
				// A new request outranks a finishing one
				user_request_register[i]     <= wmerged;
				user_request_register[i].ack <= 1'b0;
				user_request_register[i].rsv <= 3'h0;
			end else if (fin) begin
				user_request_register[i].pend <= 1'b0;
				if (!cmd.wr) begin
					user_request_register[i].data <= fr_rdata;
					user_request_register[i].ack  <= fr_ack;
				end
			end
		end

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				monitored_phy_address[i]       <= 5'h00;
				carrier_change_event_enable[i] <= 1'b0;
			end else if (hit_sel[i]) begin
				monitored_phy_address[i]       <= wmerged[4:0];
				carrier_change_event_enable[i] <= wmerged[pmsc_pkg::SEL_EN];
			end
		end

		// Set wins over a write-one-to-clear in the same cycle
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				carrier_change_raw_events[i] <= 1'b0;
				request_done_raw_events[i]   <= 1'b0;
				done_mask[i]                 <= 1'b0;
			end else begin
				carrier_change_raw_events[i] <= chg
					|| (carrier_change_raw_events[i] && !(hit_lraw && avs_writedata_i[i]));
				request_done_raw_events[i] <= fin
					|| (request_done_raw_events[i] && !(hit_draw && avs_writedata_i[i]));
				if (hit_mset && avs_writedata_i[i]) begin
					done_mask[i] <= 1'b1;
				end else if (hit_mclr && avs_writedata_i[i]) begin
					done_mask[i] <= 1'b0;
				end
			end
		end
	end

	// ***********************************************************
	// Event outputs
	// ***********************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_event_o <= 1'b0;
			link_event_o <= 1'b0;
		end else begin
			done_event_o <= |request_done_masked_events;
			link_event_o <= |carrier_change_masked_events;
		end
	end

	// ***********************************************************
	// Frame engine
	// ***********************************************************
	pmsc_frame u_frame (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.start_i     (start),
		.preamble_i  (!nopre),
		.div_i       (bus_clock_divider),
		.cmd_i       (cmd),
		.mdio_i      (mdio_i),
		.done_o      (fr_done),
		.ack_o       (fr_ack),
		.rdata_o     (fr_rdata),
		.mdc_o       (mdc_o),
		.mdio_o      (mdio_o),
		.mdio_oe_n_o (mdio_oe_n_o)
	);
endmodule : pmsc_top
`default_nettype wire

// file: logic/pmsc_pkg.sv
// Constants and types of the PHY management serial controller
package pmsc_pkg;
	// ***********************************************************
	// Timing
	// ***********************************************************
	localparam int          CLK_KHZ     = 125000;
	localparam int          MDC_MAX_KHZ = 2500;
	// Half period is divider+1 cycles
	localparam logic [15:0] DIV_RESET   = 16'((CLK_KHZ + 2 * MDC_MAX_KHZ - 1)
		/ (2 * MDC_MAX_KHZ) - 1);

	// ***********************************************************
	// Register offsets (byte addresses)
	// ***********************************************************
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_RESP   = 8'h04;
	localparam logic [7:0] OFF_CARR   = 8'h08;
	localparam logic [7:0] OFF_LRAW   = 8'h0c;
	localparam logic [7:0] OFF_LMSK   = 8'h10;
	localparam logic [7:0] OFF_DRAW   = 8'h14;
	localparam logic [7:0] OFF_DMSK   = 8'h18;
	localparam logic [7:0] OFF_MSET   = 8'h1c;
	localparam logic [7:0] OFF_MCLR   = 8'h20;
	localparam logic [7:0] OFF_REQ0   = 8'h24;
	localparam logic [7:0] OFF_REQ1   = 8'h28;
	localparam logic [7:0] OFF_SEL0   = 8'h2c;
	localparam logic [7:0] OFF_SEL1   = 8'h30;

	// ***********************************************************
	// Fields
	// ***********************************************************
	localparam int         CTRL_BUSY   = 31;
	localparam int         CTRL_EN     = 30;
	localparam int         CTRL_NOPRE  = 20;
	localparam int         SEL_EN      = 6;
	localparam logic [4:0] STATUS_REG  = 5'h01;
	localparam int         LINK_BIT    = 2;

	// ***********************************************************
	// Frame layout, bit index 0..63, preamble in 0..31
	// ***********************************************************
	localparam logic [5:0]  IDX_FRAME  = 6'h20;
	localparam logic [5:0]  IDX_TURN   = 6'h2e;
	localparam logic [5:0]  IDX_ACK    = 6'h2f;
	localparam logic [5:0]  IDX_DATA   = 6'h30;
	localparam logic [5:0]  IDX_LAST   = 6'h3f;
	localparam logic [31:0] PREAMBLE   = 32'hffffffff;
	localparam logic [1:0]  SOF        = 2'h1;
	localparam logic [1:0]  OP_RD      = 2'h2;
	localparam logic [1:0]  OP_WR      = 2'h1;
	localparam logic [1:0]  TA_WR      = 2'h2;

	typedef struct packed {
		logic        pend;
		logic        wr;
		logic        ack;
		logic [2:0]  rsv;
		logic [4:0]  regad;
		logic [4:0]  phy;
		logic [15:0] data;
	} pmsc_req_t;

	typedef struct packed {
		logic        wr;
		logic [4:0]  regad;
		logic [4:0]  phy;
		logic [15:0] data;
	} pmsc_cmd_t;
endpackage : pmsc_pkg

// file: logic/pmsc_frame.sv
// Serial frame engine: clock divider, shifter, sampler
`timescale 1ns/1ps
`default_nettype none
module pmsc_frame (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                start_i,
	input  wire logic                preamble_i,
	input  wire logic [15:0]         div_i,
	input  var  pmsc_pkg::pmsc_cmd_t cmd_i,
	input  wire logic                mdio_i,
	output logic                     done_o,
	output logic                     ack_o,
	output logic [15:0]              rdata_o,
	output logic                     mdc_o,
	output logic                     mdio_o,
	output logic                     mdio_oe_n_o
);
	typedef enum logic [1:0] {FR_IDLE = 2'b01, FR_RUN = 2'b10} pmsc_fr_t;

	pmsc_fr_t    st;
	logic [15:0] cnt;
	logic [15:0] div;
	logic [5:0]  idx;
	logic [63:0] sh;
	logic        wr;
	logic        half;
	logic        fall;
	logic        rise;

	assign half   = (cnt >= div);
	assign fall   = (st == FR_RUN) && half && mdc_o;
	assign rise   = (st == FR_RUN) && half && !mdc_o;
	assign mdio_o = sh[63];

	// ***********************************************************
	// Sequencing and bus clock
	// ***********************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st     <= FR_IDLE;
			cnt    <= 16'h0000;
			div    <= 16'h0000;
			idx    <= 6'h00;
			mdc_o  <= 1'b0;
			wr     <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (st)
				FR_IDLE: begin
					if (start_i) begin
						st    <= FR_RUN;
						cnt   <= 16'h0000;
						div   <= div_i;
						wr    <= cmd_i.wr;
						idx   <= preamble_i ? 6'h00 : pmsc_pkg::IDX_FRAME;
						mdc_o <= 1'b0;
					end
				end
				FR_RUN: begin
					if (half) begin
						cnt   <= 16'h0000;
						mdc_o <= !mdc_o;
						if (mdc_o && idx == pmsc_pkg::IDX_LAST) begin
							st     <= FR_IDLE;
							done_o <= 1'b1;
						end else if (mdc_o) begin
							idx <= idx + 6'h01;
						end
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
				default: st <= FR_IDLE;
			endcase
		end
	end

	// ***********************************************************
	// Outgoing bits change while the bus clock is low
	// ***********************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sh          <= 64'h0;
			mdio_oe_n_o <= 1'b1;
		end else if (st == FR_IDLE && start_i) begin
			sh <= {pmsc_pkg::PREAMBLE, pmsc_pkg::SOF,
				cmd_i.wr ? pmsc_pkg::OP_WR : pmsc_pkg::OP_RD,
				cmd_i.phy, cmd_i.regad, pmsc_pkg::TA_WR, cmd_i.data}
				<< (preamble_i ? 6'h00 : pmsc_pkg::IDX_FRAME);
			mdio_oe_n_o <= 1'b0;
		end else if (fall) begin
			sh <= {sh[62:0], 1'b1};
			// Reads release the line from the turnaround on
			if (idx == pmsc_pkg::IDX_LAST || (!wr && idx + 6'h01 >= pmsc_pkg::IDX_TURN)) begin
				mdio_oe_n_o <= 1'b1;
			end
		end
	end

	// ***********************************************************
	// Read sampling on rising bus clock
	// ***********************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o   <= 1'b0;
			rdata_o <= 16'h0000;
		end else if (rise && !wr) begin
			if (idx == pmsc_pkg::IDX_ACK) begin
				ack_o <= !mdio_i;
			end
			if (idx >= pmsc_pkg::IDX_DATA) begin
				rdata_o <= {rdata_o[14:0], mdio_i};
			end
		end
	end
endmodule : pmsc_frame
`default_nettype wire

// file: testbench/pmsc_chk.sv
// Port checker for the management serial controller
`timescale 1ns/1ps
`default_nettype none
module pmsc_chk (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        mdio_o,
	input wire logic        mdio_oe_n_o,
	input wire logic        mdc_o,
	input wire logic        done_event_o,
	input wire logic        link_event_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic wr_seen;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) wr_seen <= 1'b0;
		else if (avs_write_i && !avs_waitrequest_o) wr_seen <= 1'b1;
	end
	property p_quiet; !wr_seen |-> !mdc_o && mdio_oe_n_o; endproperty
	a_quiet: assert property (p_quiet) else $error("bus active before enable");
	property p_steady; mdc_o && $past(mdc_o) |-> $stable(mdio_o) && $stable(mdio_oe_n_o); endproperty
	a_steady: assert property (p_steady) else $error("data moved while clock high");
	property p_start; $fell(mdio_oe_n_o) |-> !mdc_o; endproperty
	a_start: assert property (p_start) else $error("drive began with clock high");
	property p_stop; $rose(mdio_oe_n_o) |-> !mdc_o; endproperty
	a_stop: assert property (p_stop) else $error("release with clock high");
	property p_ans; $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o; endproperty
	a_ans: assert property (p_ans) else $error("no answer to access");
	property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
	a_one: assert property (p_one) else $error("wait low too long");
	property p_hold; !(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_hold: assert property (p_hold) else $error("answer without request");
	property p_void;
		avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h30 |-> avs_readdata_o == 32'h0;
	endproperty
	a_void: assert property (p_void) else $error("unmapped read not zero");
	c_frame: cover property ($fell(mdio_oe_n_o));
	c_done: cover property ($rose(done_event_o));
	c_link: cover property ($rose(link_event_o));
endmodule : pmsc_chk
`default_nettype wire

// file: testbench/pmsc_phy.sv
// Behavioural PHY population on the shared management bus
`timescale 1ns/1ps
`default_nettype none
module pmsc_phy (
	input  wire logic        rst_n_i,
	input  wire logic        mdc_i,
	input  wire logic        dout_i,
	input  wire logic        oe_n_i,
	input  wire logic [31:0] present_i,
	input  wire logic [31:0] link_i,
	output logic             line_o
);
	logic [5:0]  n;
	logic        prev;
	logic        drv;
	logic        qo;
	logic        qe;
	logic [13:0] hd;
	logic [16:0] sh;
	logic [15:0] mem [32];
	// Pull-up holds the line high when nobody drives
	assign line_o = !oe_n_i ? dout_i : (qe ? qo : 1'b1);
	// Output moves on the falling clock, clear of the sampling edge
	always_ff @(negedge mdc_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			qe <= 1'b0;
			qo <= 1'b1;
		end else begin
			qe <= drv;
			qo <= sh[16];
		end
	end
	always_ff @(posedge mdc_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			n    <= 6'h0;
			prev <= 1'b1;
			drv  <= 1'b0;
		end else if (n == 6'h0) begin
			prev <= line_o;
			hd   <= 14'h1;
			if (!prev && line_o) n <= 6'h2;
		end else begin
			n  <= n + 6'h1;
			sh <= {sh[15:0], line_o};
			if (n < 6'he) hd <= {hd[12:0], line_o};
			if (n == 6'he && hd[11:10] == 2'h2) begin
				drv <= present_i[hd[9:5]];
				sh  <= {1'b0, hd[4:0] == 5'h1 ? {13'h0, link_i[hd[9:5]], 2'h0} : mem[hd[4:0]]};
			end
			if (n == 6'h1f) begin
				n    <= 6'h0;
				prev <= 1'b1;
				drv  <= 1'b0;
				if (hd[11:10] == 2'h1 && present_i[hd[9:5]]) mem[hd[4:0]] <= {sh[14:0], line_o};
			end
		end
	end
endmodule : pmsc_phy
`default_nettype wire

// file: testbench/tb_pmsc_top.sv
// Self-checking bench for the management serial controller
`timescale 1ns/1ps
`default_nettype none
module tb_pmsc_top;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  avs_address_i = 8'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        mdio_i;
	logic        mdio_o;
	logic        mdio_oe_n_o;
	logic        mdc_o;
	logic        done_event_o;
	logic        link_event_o;
	logic [31:0] present;
	logic [31:0] link;
	logic [31:0] q;
	logic [31:0] d;
	logic [4:0]  p;
	logic [4:0]  a;
	logic [4:0]  r;
	logic [31:0] n_rise;
	logic [31:0] n_bits;
	int          n_fail = 0;
	int          tests_run = 0;
	always #4 clk_i = ~clk_i;
	pmsc_top DUT (.*);
	pmsc_phy u_phy (.rst_n_i(rst_n_i), .mdc_i(mdc_o), .dout_i(mdio_o), .oe_n_i(mdio_oe_n_o),
		.present_i(present), .link_i(link), .line_o(mdio_i));
	// Bus clock rises since the line was taken; copied to n_bits when it is let go
	always @(posedge mdc_o or negedge mdio_oe_n_o) begin
		if (mdc_o) begin
			n_rise <= n_rise + 32'h1;
		end else begin
			n_rise <= 32'h0;
		end
	end
	always @(posedge mdio_oe_n_o) begin
		n_bits <= n_rise;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge clk_i);
		avs_address_i   <= ad;
		avs_writedata_i <= wd;
		avs_read_i      <= !w;
		avs_write_i     <= w;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
		bus(1'b0, ad, 32'h0);
		chk(q, exp);
	endtask : rd
	task automatic idle(input logic [7:0] ad);
		do bus(1'b0, ad, 32'h0); while (q[31] !== 1'b0);
	endtask : idle
	function automatic logic [31:0] req(input logic [2:0] f, input logic [4:0] rg, ph,
		input logic [15:0] v);
		return {f, 3'h0, rg, ph, v};
	endfunction : req
	task automatic close_out;
		$display("checks=%0d failures=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	initial begin
		repeat (40000) @(posedge clk_i);
		n_fail++;
		close_out();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		void'($urandom(32'h4c66));
		present = $urandom;
		p = 5'($urandom);
		a = p + 5'h1;
		present[p] = 1'b1;
		present[a] = 1'b0;
		link = $urandom & present;
		d = $urandom;
		r = 5'h2 + 5'($urandom % 30);
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(pmsc_pkg::OFF_CTRL, {16'h0, pmsc_pkg::DIV_RESET});
		rd(8'h3c, 32'h0);
		bus(1'b1, pmsc_pkg::OFF_CTRL, 32'h4000_0000);
		repeat (9000) @(posedge clk_i);
		rd(pmsc_pkg::OFF_RESP, present);
		rd(pmsc_pkg::OFF_CARR, link);
		bus(1'b1, pmsc_pkg::OFF_SEL0, {25'h0, 2'h2, p});
		bus(1'b1, pmsc_pkg::OFF_SEL1, {25'h0, 2'h2, a});
		link[p] = ~link[p];
		repeat (9000) @(posedge clk_i);
		rd(pmsc_pkg::OFF_CARR, link);
		rd(pmsc_pkg::OFF_LRAW, 32'h1);
		rd(pmsc_pkg::OFF_LMSK, 32'h1);
		chk({31'h0, link_event_o}, 32'h1);
		bus(1'b1, pmsc_pkg::OFF_MSET, 32'h1);
		bus(1'b1, pmsc_pkg::OFF_REQ0, req(3'h6, r, p, d[15:0]));
		bus(1'b1, pmsc_pkg::OFF_REQ1, req(3'h4, r, p, 16'h0));
		idle(pmsc_pkg::OFF_REQ1);
		chk(q, req(3'h1, r, p, d[15:0]));
		chk(n_bits, 32'h2e);
		idle(pmsc_pkg::OFF_REQ0);
		rd(pmsc_pkg::OFF_DRAW, 32'h3);
		rd(pmsc_pkg::OFF_DMSK, 32'h1);
		chk({31'h0, done_event_o}, 32'h1);
		bus(1'b1, pmsc_pkg::OFF_MCLR, 32'h1);
		rd(pmsc_pkg::OFF_DMSK, 32'h0);
		chk({31'h0, done_event_o}, 32'h0);
		bus(1'b1, pmsc_pkg::OFF_REQ0, req(3'h4, 5'h1, a, 16'h0));
		idle(pmsc_pkg::OFF_REQ0);
		chk({31'h0, q[29]}, 32'h0);
		present[a] = 1'b1;
		bus(1'b1, pmsc_pkg::OFF_REQ1, req(3'h4, 5'h1, a, 16'h0));
		idle(pmsc_pkg::OFF_REQ1);
		chk(q, req(3'h1, 5'h1, a, 16'h0));
		rd(pmsc_pkg::OFF_RESP, present);
		bus(1'b1, pmsc_pkg::OFF_CTRL, 32'h4010_0000);
		bus(1'b1, pmsc_pkg::OFF_REQ1, req(3'h4, r, p, 16'h0));
		idle(pmsc_pkg::OFF_REQ1);
		chk(q, req(3'h1, r, p, d[15:0]));
		chk(n_bits, 32'h0e);
		bus(1'b1, pmsc_pkg::OFF_CTRL, 32'h0);
		repeat (200) @(posedge clk_i);
		bus(1'b1, pmsc_pkg::OFF_REQ0, req(3'h4, r, p, 16'h0));
		repeat (300) @(posedge clk_i);
		rd(pmsc_pkg::OFF_REQ0, req(3'h4, r, p, 16'h0));
		bus(1'b1, pmsc_pkg::OFF_CTRL, 32'h4000_0003);
		idle(pmsc_pkg::OFF_REQ0);
		chk(q, req(3'h1, r, p, d[15:0]));
		chk(n_bits, 32'h2e);
		close_out();
	end
endmodule : tb_pmsc_top
bind pmsc_top pmsc_chk u_chk (.*);
`default_nettype wire
